// File: bench/ext_agent_props.sv
// checker on the pins of the external agent controller
// assumes: bound to ext_agent_ctrl, one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "extagent_regs.vh"
module ext_agent_props (
  input wire CLK_SYS, // clock
  input wire RESETN, // reset, active low
  input wire EXT_ARB_REQ_N, // arbitration
  input wire RELEASE_N, // release strobe
  input wire AGENT_VALID_N, // agent strobe
  input wire [31:0] MUX_AD_OUT, // bus value
  input wire MUX_AD_OE, // bus enable
  input wire [8:0] CMD_ID_OUT, // command value
  input wire CMD_ID_OE, // command enable
  input wire CHK_OE // check enable
);
  // ****************************************************************
  // pin timing
  // ****************************************************************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  sequence s_wr_addr;
    !AGENT_VALID_N && !CMD_ID_OUT[8] && CMD_ID_OUT[7:5] == `CMD_CODE_WRITE;
  endsequence
  sequence s_drive_end;
    !AGENT_VALID_N ##1 AGENT_VALID_N;
  endsequence
  a_strobe_drives: assert property (!AGENT_VALID_N |-> MUX_AD_OE && CMD_ID_OE)
    else $error("strobe without drive");
  a_chk_tracks_bus: assert property (CHK_OE == MUX_AD_OE)
    else $error("check bits out of step");
  a_release_gap: assert property (!RELEASE_N |=> (!MUX_AD_OE && !CMD_ID_OE) [*2])
    else $error("drive too soon");
  a_arb_hold_two: assert property (!RELEASE_N && !EXT_ARB_REQ_N |=> !EXT_ARB_REQ_N [*2])
    else $error("arbitration dropped early");
  a_float_after: assert property (s_drive_end |-> !MUX_AD_OE && !CMD_ID_OE && !CHK_OE)
    else $error("bus not floated");
  a_write_data: assert property (s_wr_addr |=>
    (!AGENT_VALID_N && CMD_ID_OUT[8] && CMD_ID_OUT[`ID_LAST]) ##1 AGENT_VALID_N)
    else $error("bad write data cycle");
  a_write_addr_ok: assert property (s_wr_addr |-> MUX_AD_OUT[6:4] == 3'h0)
    else $error("write address bits set");
  a_single_strobe: assert property (!AGENT_VALID_N && !CMD_ID_OUT[8] &&
    CMD_ID_OUT[7:5] != `CMD_CODE_WRITE |=> AGENT_VALID_N && !MUX_AD_OE)
    else $error("request longer than one cycle");
  a_resp_flagged: assert property (!AGENT_VALID_N && CMD_ID_OUT[8] && $past(AGENT_VALID_N)
    |-> CMD_ID_OUT[`ID_RESP])
    else $error("response not flagged");
endmodule // ext_agent_props
bind ext_agent_ctrl ext_agent_props u_props (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .EXT_ARB_REQ_N(EXT_ARB_REQ_N), .RELEASE_N(RELEASE_N), .AGENT_VALID_N(AGENT_VALID_N),
  .MUX_AD_OUT(MUX_AD_OUT), .MUX_AD_OE(MUX_AD_OE), .CMD_ID_OUT(CMD_ID_OUT),
  .CMD_ID_OE(CMD_ID_OE), .CHK_OE(CHK_OE));

// File: bench/proc_model.sv
// behavioural processor side of the multiplexed system interface
// assumes: agent pins arrive undelayed; reads are started only while master
`timescale 1ns/1ps
module proc_model #(
  parameter [31:0] ANS = 32'h00000000 // external read answer, arbitrary
) (
  input wire clk, // clock
  input wire rst_n, // reset
  input wire arb_n, // arbitration
  input wire av_n, // agent strobe
  input wire rar_n, // read ready
  input wire [31:0] ad_o, // agent bus
  input wire ad_oe, // agent bus enable
  input wire [8:0] cmd_o, // agent command
  input wire cmd_oe, // command enable
  input wire [3:0] chk_o, // agent check bits
  input wire chk_oe, // check enable
  input wire start, // begin reads
  input wire [2:0] nrd, // reads wanted
  input wire [31:0] base, // first read address
  output reg rel_n, // release strobe
  output reg pv_n, // processor strobe
  output wire [31:0] ad_i, // bus level
  output wire [8:0] cmd_i, // command level
  output wire [3:0] chk_i // check level
);
  // ****************************************************************
  // bus levels and processor state
  // ****************************************************************
  reg [31:0] p_ad, ad_idle, wr_addr, wr_data, resp_data;
  reg [8:0] p_cmd, cmd_idle;
  reg [3:0] chk_idle;
  reg [7:0] wr_cnt, null_cnt, resp_cnt, resp_err;
  reg [2:0] pend, left;
  reg [1:0] ans;
  reg p_oe, slave, back, wrd;
  // released lines flip every cycle so a stale value can never pass
  assign ad_i = ad_oe ? ad_o : p_oe ? p_ad : ad_idle;
  assign cmd_i = cmd_oe ? cmd_o : p_oe ? p_cmd : cmd_idle;
  assign chk_i = chk_oe ? chk_o : p_oe ? 4'h0 : chk_idle;
  always @(posedge clk) begin
    ad_idle <= rst_n ? ~ad_i : 32'h0;
    cmd_idle <= rst_n ? ~cmd_i : 9'h0;
    chk_idle <= rst_n ? ~chk_i : 4'h0;
  end
  always @(posedge clk) begin
    rel_n <= 1'b1;
    pv_n <= 1'b1;
    p_oe <= 1'b0;
    if (!rst_n) begin
      {slave, back, wrd, ans, pend, left} <= 11'h0;
      {wr_cnt, null_cnt, resp_cnt, resp_err} <= 32'h0;
    end else if (back) begin
      back <= 1'b0; // master one cycle after the agent floats
      slave <= 1'b0;
    end else if (ans != 2'h0) begin
      ans <= ans - 2'h1;
      if (ans == 2'h1) begin // undefined data, erroneous bit set
        pv_n <= 1'b0;
        p_oe <= 1'b1;
        p_cmd <= 9'h1A0;
        p_ad <= ANS;
        slave <= 1'b0;
      end
    end else if (!slave) begin
      if (start) begin
        left <= nrd;
      end else if (left != 3'h0 && pv_n && pend < 3'h4 && !rar_n) begin
        pv_n <= 1'b0;
        p_oe <= 1'b1;
        p_cmd <= 9'h000;
        p_ad <= base + {pend, 4'h0};
        pend <= pend + 3'h1;
        left <= left - 3'h1;
      end else if (pend != 3'h0 && pv_n) begin // uncompelled, four reads at most
        rel_n <= 1'b0;
        slave <= 1'b1;
        left <= 3'h0;
      end else if (!arb_n) begin // one-cycle release only when idle
        rel_n <= 1'b0;
        slave <= 1'b1;
      end
    end else if (!av_n) begin
      if (!cmd_i[8]) begin
        case (cmd_i[7:5])
          3'h0: ans <= 2'h2; // answered after two floating cycles
          3'h2: begin // bad address bits: cycle ignored
            wr_addr <= ad_i;
            wrd <= (ad_i[6:4] == 3'h0);
            back <= (ad_i[6:4] != 3'h0);
          end
          default: begin
            null_cnt <= null_cnt + 8'h1;
            back <= 1'b1;
          end
        endcase
      end else if (wrd) begin // one last-flagged data word
        wr_data <= ad_i;
        wrd <= 1'b0;
        wr_cnt <= wr_cnt + 8'h1;
        back <= 1'b1;
      end else if (cmd_i[6]) begin // last cycle retires oldest read
        resp_data <= ad_i;
        resp_err <= resp_err + {7'h0, cmd_i[5]};
        if (cmd_i[7]) begin
          pend <= pend - 3'h1;
          resp_cnt <= resp_cnt + 8'h1;
          back <= (pend == 3'h1);
        end
      end
    end
  end
endmodule // proc_model

// File: bench/tb_ext_agent_ctrl.sv
// self-checking bench: AXI4-Lite orders in, processor model on the pins
// assumes: design sources and header on the include path
`timescale 1ns/1ps
`include "extagent_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_ext_agent_ctrl;
  localparam [31:0] ANS = 32'h5A5A0F0F;
  reg clk = 0;
  reg rst_n = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, base = 0, d;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, start = 0;
  reg [2:0] nrd = 0;
  reg [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, arb_n, rel_n, av_n, pv_n, rar_n;
  wire ad_oe, cmd_oe, chk_oe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, ad_o, ad_i;
  wire [8:0] cmd_o, cmd_i;
  wire [3:0] chk_o, chk_i;
  integer failures = 0, tests_run = 0, i;
  always #20 clk = ~clk;
  ext_agent_ctrl dut (.CLK_SYS(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EXT_ARB_REQ_N(arb_n), .RELEASE_N(rel_n), .AGENT_VALID_N(av_n), .PROC_VALID_N(pv_n),
    .READ_ACCEPT_READY_N(rar_n), .WRITE_ACCEPT_READY_N(), .MUX_AD_IN(ad_i),
    .MUX_AD_OUT(ad_o), .MUX_AD_OE(ad_oe), .CMD_ID_IN(cmd_i), .CMD_ID_OUT(cmd_o),
    .CMD_ID_OE(cmd_oe), .CHK_IN(chk_i), .CHK_OUT(chk_o), .CHK_OE(chk_oe));
  proc_model #(.ANS(ANS)) u_proc (.clk(clk), .rst_n(rst_n), .arb_n(arb_n), .av_n(av_n),
    .rar_n(rar_n), .ad_o(ad_o), .ad_oe(ad_oe), .cmd_o(cmd_o), .cmd_oe(cmd_oe),
    .chk_o(chk_o), .chk_oe(chk_oe), .start(start), .nrd(nrd), .base(base),
    .rel_n(rel_n), .pv_n(pv_n), .ad_i(ad_i), .cmd_i(cmd_i), .chk_i(chk_i));
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task results;
    begin
      $display("tests_run %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ready and response are sampled mid-cycle, acted on at the next edge
  task wr(input [7:0] a, input [31:0] v);
    integer n;
    reg ha, hw, hb;
    begin
      hb = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (n = 0; n < 100 && !hb; n++) begin
        @(negedge clk);
        ha = awvalid && awready;
        hw = wvalid && wready;
        hb = bvalid;
        r = bresp;
        @(posedge clk);
        if (ha) awvalid <= 0;
        if (hw) wvalid <= 0;
        if (hb) bready <= 0;
      end
      if (!hb) begin
        failures++;
        results;
      end
    end
  endtask
  task rd(input [7:0] a);
    integer n;
    reg ha, hr;
    begin
      hr = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (n = 0; n < 100 && !hr; n++) begin
        @(negedge clk);
        ha = arvalid && arready;
        hr = rvalid;
        d = rdata;
        r = rresp;
        @(posedge clk);
        if (ha) arvalid <= 0;
        if (hr) rready <= 0;
      end
      if (!hr) begin
        failures++;
        results;
      end
    end
  endtask
  task poll(input [31:0] m, input [31:0] e);
    integer n;
    begin
      rd(`OFS_STATUS);
      for (n = 0; n < 60 && (d & m) !== e; n++) rd(`OFS_STATUS);
      `CHK("status", e, d & m)
      if ((d & m) !== e) results;
    end
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rd(`OFS_STATUS);
    `CHK("status", 32'h0, d)
    `CHK("arb", 1'b1, arb_n)
    rd(8'h40);
    `CHK("rresp", `RESP_SLVERR, r)
    wr(8'h40, 32'h0);
    `CHK("bresp", `RESP_SLVERR, r)
    wr(`OFS_ADDR, 32'h00001208);
    wr(`OFS_WDATA, 32'hA5C31E70);
    wr(`OFS_CTRL, 32'h5);
    poll(32'h5, 32'h0);
    `CHK("arb bit", 1'b0, d[3])
    `CHK("wr addr", 32'h00001208, u_proc.wr_addr)
    `CHK("wr data", 32'hA5C31E70, u_proc.wr_data)
    `CHK("chk", 4'h1, chk_o)
    `CHK("proc slave", 1'b0, u_proc.slave)
    wr(`OFS_ADDR, 32'h00000100);
    wr(`OFS_CTRL, 32'h4);
    poll(32'h405, 32'h400);
    rd(`OFS_RD_DATA);
    `CHK("rd data", ANS, d)
    wr(`OFS_STATUS, 32'h400);
    wr(`OFS_CTRL, 32'h6);
    wr(`OFS_CTRL, 32'h6);
    poll(32'h605, 32'h200);
    `CHK("nulls", 8'h1, u_proc.null_cnt)
    wr(`OFS_STATUS, 32'h200);
    base <= 32'h2000;
    nrd <= 3'h5;
    start <= 1;
    @(posedge clk);
    start <= 0;
    poll(32'h74, 32'h44);
    `CHK("read ready", 1'b1, rar_n)
    for (i = 0; i < 4; i++) begin
      rd(`OFS_HEAD_ADDR);
      `CHK("head", 32'h2000 + 16 * i, d)
      wr(`OFS_RESP_DATA, 32'hC0DE0000 + i);
      wr(`OFS_RESP_CTRL, i == 1 ? 32'h7 : 32'h5);
      poll(32'h2, 32'h0);
      `CHK("resp", 32'hC0DE0000 + i, u_proc.resp_data)
    end
    poll(32'h74, 32'h0);
    `CHK("resp count", 8'h4, u_proc.resp_cnt)
    `CHK("resp err", 8'h1, u_proc.resp_err)
    wr(`OFS_RESP_CTRL, 32'h5);
    poll(32'h202, 32'h200);
    wr(`OFS_ADDR, 32'h00000010);
    wr(`OFS_CTRL, 32'h5);
    poll(32'h105, 32'h100);
    `CHK("writes", 8'h1, u_proc.wr_cnt)
    `CHK("nulls", 8'h2, u_proc.null_cnt)
    results;
  end
endmodule // tb_ext_agent_ctrl

// File: core/ext_agent_ctrl.v
// external agent controller for a multiplexed address/data system interface
// assumes: processor pins are asynchronous (2-flop sampled); software on AXI4-Lite
//
// How it works
// - external requests are driven only while the interface is in slave state.
// - raise arbitration request, wait release; start at once after uncompelled release.
// - drop arbitration request on seeing release unless a string is held.
// - external write address bits 6 to 4 must be zero, else refused.
// - agent drives buses no sooner than two cycles after release.
// - agent floats buses on completion; processor drives one cycle later.
// - check bits follow the address/data bus drive and timing.
// - external read is one word, nothing between request and its response.
// - external read: command, address, valid one cycle, then float, await answer.
// - null request: null command with one valid cycle, then release buses.
// - external write: command plus address, then one last-flagged data cycle.
// - read response after slave change; float buses after last cycle.
// - every response cycle is flagged response; final one also flagged last.
// - responses go back in processor request order.
// - response cycles may carry error flag, full size still delivered.
// - response data only while a processor read is pending.
// - after an error, remaining outstanding reads are still answered.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "extagent_regs.vh"
module ext_agent_ctrl (
  input wire CLK_SYS, // system clock, 25 MHz
  input wire RESETN, // synchronous reset, active low
  input wire [7:0] S_AXI_AWADDR, // write address
  input wire S_AXI_AWVALID, // write address valid
  output wire S_AXI_AWREADY, // write address ready
  input wire [31:0] S_AXI_WDATA, // write data
  input wire [3:0] S_AXI_WSTRB, // write byte enables
  input wire S_AXI_WVALID, // write data valid
  output wire S_AXI_WREADY, // write data ready
  output reg [1:0] S_AXI_BRESP, // write response
  output reg S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire [7:0] S_AXI_ARADDR, // read address
  input wire S_AXI_ARVALID, // read address valid
  output wire S_AXI_ARREADY, // read address ready
  output reg [31:0] S_AXI_RDATA, // read data
  output reg [1:0] S_AXI_RRESP, // read response
  output reg S_AXI_RVALID, // read data valid
  input wire S_AXI_RREADY, // read data ready
  output reg EXT_ARB_REQ_N, // external arbitration request, active low
  input wire RELEASE_N, // processor release strobe, active low
  output reg AGENT_VALID_N, // agent valid strobe, active low
  input wire PROC_VALID_N, // processor valid strobe, active low
  output wire READ_ACCEPT_READY_N, // agent can take a read, active low
  output wire WRITE_ACCEPT_READY_N, // agent can take a write, active low
  input wire [31:0] MUX_AD_IN, // muxed address/data bus, pin level
  output reg [31:0] MUX_AD_OUT, // muxed address/data bus, driven value
  output reg MUX_AD_OE, // muxed address/data bus drive enable
  input wire [8:0] CMD_ID_IN, // command/identifier bus, pin level
  output reg [8:0] CMD_ID_OUT, // command/identifier bus, driven value
  output reg CMD_ID_OE, // command/identifier bus drive enable
  input wire [3:0] CHK_IN, // data check bits, pin level
  output reg [3:0] CHK_OUT, // data check bits, driven value
  output reg CHK_OE // data check bits drive enable
);
  // ****************************************************************
  // state codes
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_WDATA = 3'h2;
  localparam [2:0] S_RDWAIT = 3'h3;
  localparam [2:0] S_RESP = 3'h4;

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  wire [46:0] pins_s;
  wire release_seen = !pins_s[46];
  wire proc_valid = !pins_s[45];
  wire [8:0] cmd_s = pins_s[44:36];
  wire [31:0] ad_s = pins_s[35:4];
  wire [3:0] chk_s = pins_s[3:0];

  pin_sync2 #(
    .WIDTH(47),
    .INIT({2'h3, 45'h0})
  ) u_sync (
    .CLK_SYS(CLK_SYS),
    .RESETN(RESETN),
    .D({RELEASE_N, PROC_VALID_N, CMD_ID_IN, MUX_AD_IN, CHK_IN}),
    .Q(pins_s)
  );

  // ****************************************************************
  // registers and state
  // ****************************************************************
  reg [2:0] state;
  reg slave; // interface is in slave state, buses are ours
  reg ext_pend;
  reg [1:0] ext_kind;
  reg hold;
  reg [31:0] ext_addr;
  reg [31:0] ext_wdata;
  reg resp_pend;
  reg resp_last;
  reg resp_err;
  reg [31:0] resp_data;
  reg [31:0] rd_data;
  reg [3:0] rd_chk;
  reg waddr_err;
  reg refused;
  reg rd_err;
  reg [31:0] rdq [0:3];
  reg [1:0] q_wr;
  reg [1:0] q_rd;
  reg [2:0] q_cnt;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire [31:0] status = {17'h0, rd_chk, rd_err, refused, waddr_err, 1'b0, q_cnt,
                        !EXT_ARB_REQ_N, slave, resp_pend, ext_pend};
  wire proc_rd_req = proc_valid && !cmd_s[`CMD_IS_DATA] &&
                     cmd_s[`CMD_CODE_HI:`CMD_CODE_LO] == `CMD_CODE_READ;
  wire bad_waddr = ext_addr[`WADDR_CHK_HI:`WADDR_CHK_LO] != 3'h0;
  wire wr_go = aw_held && w_held && !S_AXI_BVALID;

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  // full queue holds off further processor reads
  assign READ_ACCEPT_READY_N = (q_cnt == `RDQ_DEPTH);
  assign WRITE_ACCEPT_READY_N = 1'b0;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  function [3:0] parity;
    input [31:0] d;
    begin
      parity = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    end
  endfunction

  // drive all three buses together, check bits tracking the data bus
  task drive;
    input [8:0] c;
    input [31:0] d;
    begin
      CMD_ID_OUT <= c;
      MUX_AD_OUT <= d;
      CHK_OUT <= parity(d);
      CMD_ID_OE <= 1'b1;
      MUX_AD_OE <= 1'b1;
      CHK_OE <= 1'b1;
      AGENT_VALID_N <= 1'b0;
    end
  endtask

  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      S_AXI_BRESP <= `RESP_OKAY;
      S_AXI_BVALID <= 1'b0;
      S_AXI_RDATA <= `ZERO32;
      S_AXI_RRESP <= `RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `ZERO32;
      w_strb <= 4'h0;
      EXT_ARB_REQ_N <= 1'b1;
      AGENT_VALID_N <= 1'b1;
      MUX_AD_OUT <= `ZERO32;
      MUX_AD_OE <= 1'b0;
      CMD_ID_OUT <= 9'h000;
      CMD_ID_OE <= 1'b0;
      CHK_OUT <= 4'h0;
      CHK_OE <= 1'b0;
      state <= S_IDLE;
      slave <= 1'b0;
      ext_pend <= 1'b0;
      ext_kind <= `KIND_NULL;
      hold <= 1'b0;
      ext_addr <= `ZERO32;
      ext_wdata <= `ZERO32;
      resp_pend <= 1'b0;
      resp_last <= 1'b0;
      resp_err <= 1'b0;
      resp_data <= `ZERO32;
      rd_data <= `ZERO32;
      rd_chk <= 4'h0;
      waddr_err <= 1'b0;
      refused <= 1'b0;
      rd_err <= 1'b0;
      q_wr <= 2'h0;
      q_rd <= 2'h0;
      q_cnt <= 3'h0;
    end else begin
      // ****************************************************************
      // AXI4-Lite slave
      // ****************************************************************
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `RESP_OKAY;
        case (aw_addr)
          `OFS_CTRL: begin
            if (w_strb[0]) begin
              hold <= w_data[`CTRL_HOLD];
              // a new order while one is open is dropped and flagged
              if (w_data[`CTRL_GO] && ext_pend) begin
                refused <= 1'b1;
              end else if (w_data[`CTRL_GO]) begin
                ext_pend <= 1'b1;
                ext_kind <= w_data[`CTRL_KIND_HI:`CTRL_KIND_LO];
              end
            end
          end
          `OFS_ADDR: ext_addr <= merge(ext_addr, w_data, w_strb);
          `OFS_WDATA: ext_wdata <= merge(ext_wdata, w_data, w_strb);
          `OFS_RESP_DATA: resp_data <= merge(resp_data, w_data, w_strb);
          `OFS_RESP_CTRL: begin
            if (w_strb[0] && w_data[`RESP_GO]) begin
              if (resp_pend || q_cnt == 3'h0) begin
                refused <= 1'b1;
              end else begin
                resp_pend <= 1'b1;
                resp_last <= w_data[`RESP_LAST];
                resp_err <= w_data[`RESP_ERR];
              end
            end
          end
          `OFS_STATUS: begin
            if (w_strb[1]) begin
              if (w_data[`ST_WADDR_ERR]) waddr_err <= 1'b0;
              if (w_data[`ST_REFUSED]) refused <= 1'b0;
              if (w_data[`ST_RD_ERR]) rd_err <= 1'b0;
            end
          end
          default: S_AXI_BRESP <= `RESP_SLVERR;
        endcase
      end
      if (S_AXI_RVALID && S_AXI_RREADY) S_AXI_RVALID <= 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `RESP_OKAY;
        case (S_AXI_ARADDR)
          `OFS_CTRL: S_AXI_RDATA <= {28'h0, hold, ext_pend, ext_kind};
          `OFS_ADDR: S_AXI_RDATA <= ext_addr;
          `OFS_WDATA: S_AXI_RDATA <= ext_wdata;
          `OFS_RESP_DATA: S_AXI_RDATA <= resp_data;
          `OFS_RESP_CTRL: S_AXI_RDATA <= {29'h0, resp_pend, resp_err, resp_last};
          `OFS_STATUS: S_AXI_RDATA <= status;
          `OFS_HEAD_ADDR: S_AXI_RDATA <= rdq[q_rd];
          `OFS_RD_DATA: S_AXI_RDATA <= rd_data;
          default: begin
            S_AXI_RDATA <= `ZERO32;
            S_AXI_RRESP <= `RESP_SLVERR;
          end
        endcase
      end

      // ****************************************************************
      // arbitration and processor read capture
      // ****************************************************************
      // release reaches us two cycles late, so driving from here keeps the gap
      if (release_seen && !slave) begin
        slave <= 1'b1;
        if (!hold) EXT_ARB_REQ_N <= 1'b1;
      end
      if (!slave && proc_rd_req && q_cnt != `RDQ_DEPTH) begin
        rdq[q_wr] <= ad_s;
        q_wr <= q_wr + 2'h1;
        q_cnt <= q_cnt + 3'h1;
      end

      // ****************************************************************
      // bus sequencer
      // ****************************************************************
      case (state)
        S_IDLE: begin
          if (ext_pend && !slave && EXT_ARB_REQ_N && !release_seen) begin
            EXT_ARB_REQ_N <= 1'b0;
          end
          if (slave && ext_pend) begin
            if (ext_kind == `KIND_WRITE && bad_waddr) begin
              drive({1'b0, `CMD_CODE_NULL, 5'h00}, `ZERO32);
              ext_kind <= `KIND_NULL;
              waddr_err <= 1'b1;
              state <= S_ADDR;
            end else if (ext_kind == `KIND_WRITE) begin
              drive({1'b0, `CMD_CODE_WRITE, 5'h00}, ext_addr);
              state <= S_ADDR;
            end else if (ext_kind == `KIND_READ) begin
              drive({1'b0, `CMD_CODE_READ, 5'h00}, ext_addr);
              state <= S_ADDR;
            end else begin
              drive({1'b0, `CMD_CODE_NULL, 5'h00}, `ZERO32);
              state <= S_ADDR;
            end
          end else if (slave && resp_pend && q_cnt != 3'h0) begin
            drive({1'b1, resp_last, 1'b1, resp_err, 5'h00}, resp_data);
            state <= S_RESP;
          end
        end
        S_ADDR: begin
          if (ext_kind == `KIND_WRITE) begin
            drive({1'b1, 1'b1, 1'b0, 1'b0, 5'h00}, ext_wdata);
            state <= S_WDATA;
          end else begin
            AGENT_VALID_N <= 1'b1;
            CMD_ID_OE <= 1'b0;
            MUX_AD_OE <= 1'b0;
            CHK_OE <= 1'b0;
            if (ext_kind == `KIND_READ) begin
              state <= S_RDWAIT;
            end else begin
              slave <= 1'b0;
              ext_pend <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_WDATA: begin
          AGENT_VALID_N <= 1'b1;
          CMD_ID_OE <= 1'b0;
          MUX_AD_OE <= 1'b0;
          CHK_OE <= 1'b0;
          slave <= 1'b0;
          ext_pend <= 1'b0;
          state <= S_IDLE;
        end
        S_RDWAIT: begin
          // nothing else is issued until the processor answers
          if (proc_valid && cmd_s[`CMD_IS_DATA]) begin
            rd_data <= ad_s;
            rd_chk <= chk_s;
            if (cmd_s[`ID_ERR]) rd_err <= 1'b1;
            slave <= 1'b0;
            ext_pend <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_RESP: begin
          AGENT_VALID_N <= 1'b1;
          CMD_ID_OE <= 1'b0;
          MUX_AD_OE <= 1'b0;
          CHK_OE <= 1'b0;
          resp_pend <= 1'b0;
          if (resp_last) begin
            q_rd <= q_rd + 2'h1;
            q_cnt <= q_cnt - 3'h1;
            if (q_cnt == 3'h1) slave <= 1'b0;
          end
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // ext_agent_ctrl

// File: core/extagent_regs.vh
// offsets, fields, command codes and sizes for the external agent controller
// assumes: 8-bit AXI4-Lite byte addresses, 32-bit data, one aligned word per register
`ifndef EXTAGENT_REGS_VH
`define EXTAGENT_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_RESP_DATA 8'h0C
`define OFS_RESP_CTRL 8'h10
`define OFS_STATUS 8'h14
`define OFS_HEAD_ADDR 8'h18
`define OFS_RD_DATA 8'h1C

// ****************************************************************
// control fields
// ****************************************************************
`define CTRL_KIND_LO 0
`define CTRL_KIND_HI 1
`define CTRL_GO 2
`define CTRL_HOLD 3
`define KIND_READ 2'h0
`define KIND_WRITE 2'h1
`define KIND_NULL 2'h2
`define RESP_LAST 0
`define RESP_ERR 1
`define RESP_GO 2

// ****************************************************************
// status fields
// ****************************************************************
`define ST_EXT_PEND 0
`define ST_RESP_PEND 1
`define ST_SLAVE 2
`define ST_ARB 3
`define ST_QCNT_LO 4
`define ST_QCNT_HI 6
`define ST_WADDR_ERR 8
`define ST_REFUSED 9
`define ST_RD_ERR 10

// ****************************************************************
// command / identifier bus encoding
// ****************************************************************
`define CMD_IS_DATA 8
`define CMD_CODE_HI 7
`define CMD_CODE_LO 5
`define CMD_CODE_READ 3'h0
`define CMD_CODE_WRITE 3'h2
`define CMD_CODE_NULL 3'h3
`define ID_LAST 7
`define ID_RESP 6
`define ID_ERR 5
`define WADDR_CHK_HI 6
`define WADDR_CHK_LO 4

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define RDQ_DEPTH 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h00000000

`endif

// File: core/pin_sync2.v
// two flip-flop synchroniser for a group of pin inputs
// assumes: inputs are asynchronous to CLK_SYS; only the second stage is read outside
`timescale 1ns/1ps
module pin_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire CLK_SYS, // system clock
  input wire RESETN, // synchronous reset, active low
  input wire [WIDTH-1:0] D, // raw pin levels
  output reg [WIDTH-1:0] Q // synchronised levels
);
  reg [WIDTH-1:0] stage1;

  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      stage1 <= INIT;
      Q <= INIT;
    end else begin
      stage1 <= D;
      Q <= stage1;
    end
  end
endmodule // pin_sync2
